// ---- core/lin_frame_map.svh ----
// constants for the lin command frames, fields and host registers
`ifndef LIN_FRAME_MAP_SVH
`define LIN_FRAME_MAP_SVH

// frame identifiers (6-bit)
`define FID_COLOR 6'h10
`define FID_DIRECT 6'h11
`define FID_NVM 6'h12
// data byte counts per frame
`define LEN_COLOR 3'h3
`define LEN_CMD 3'h4
// location codes
`define LOC_BROADCAST 8'h00
`define LOC_SUPER 8'h40
`define LOC_SUPER_LO 4'h5
`define LOC_SUPER_HI 4'h8
`define LOC_UNCONFIG 8'hFF
// nvm write frame byte 1
`define NVM_ERASE_BIT 7
`define NVM_ZERO_BIT 6
`define NVM_MAX_INDEX 6'h10
// color frame fields, and the nvm word index top bit
`define COL_UPDATE_BIT 6
`define COL_TRANS_EN_BIT 1
`define COL_TRANS_T0_BIT 7
`define COL_TRANS_T1_BIT 4
`define COL_TRANS_T2_BIT 5
`define COL_POINT_HI 5
`define COL_POINT_LO 2
`define INT_MODE_HI 7
`define INT_MODE_LO 6
`define INT_VALUE_HI 3
`define NVM_INDEX_HI 5
`define INT_MODE_APPLY 2'h0
`define INT_MODE_STORE 2'h1
`define INT_MODE_STORED 2'h2
// host registers, byte addresses
`define ADDR_DATA 4'h0
`define ADDR_CTRL 4'h4
`define ADDR_GO 4'h8
`define ADDR_STATUS 4'hC
// host ctrl and status fields
`define KIND_COLOR 2'h0
`define KIND_DIRECT 2'h1
`define KIND_NVM 2'h2
`define CTRL_PROD_BIT 2
`define ST_BUSY_BIT 0
`define ST_SENT_BIT 1
`define ST_DROP_BIT 2

`endif

// ---- core/lin_frame_pkg.sv ----
// types and checksum helpers shared by both ends of the frame link
package lin_frame_pkg;

  typedef enum logic [0:0] {ST_IDLE, ST_SEND} host_state_t;

  // protected identifier: id plus two parity bits
  function automatic logic [7:0] makePid(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // enhanced checksum: inverted sum with carry over pid and data bytes
  function automatic logic [7:0] enhCks(input logic [7:0] pid,
                                        input logic [31:0] data,
                                        input logic [2:0] len);
    logic [8:0] s;
    s = {1'b0, pid};
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < len) begin
        s = s + {1'b0, data[8*i +: 8]};
        if (s[8]) begin
          s = s - 9'h0FF;
        end
      end
    end
    return ~s[7:0];
  endfunction

endpackage

// ---- core/lin_frame_if.sv ----
// frame-level link between the bus master and the led slave decoder
interface lin_frame_if;
  logic frmValid;
  logic [7:0] frmPid;
  logic [31:0] frmData;
  logic [2:0] frmLen;
  logic [7:0] frmCks;

  modport master (output frmValid, frmPid, frmData, frmLen, frmCks);
  modport slave (input frmValid, frmPid, frmData, frmLen, frmCks);
endinterface

// ---- core/lin_cmd_decoder.sv ----
// led slave end: decodes direct intensity, colour and nvm write frames
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "lin_frame_map.svh"

// Notes on behaviour
// - frames need a good enhanced checksum
// - direct frame: location, then three channel bytes
// - act only when location selects this slave
// - good direct frame loads three channel levels
// - use last colour frame transition settings
// - direct frame replaces earlier colour selection
// - hold levels until direct or refresh frame
// - master sends colour frame after, refresh 0
// - nvm frame outside programming mode silently dropped
// - master uses nvm frame only in production
// - byte 1 low bits: word index up to 0x10
// - master sends byte 1 bit 6 as zero
// - bit 7 set means erase then write
// - bytes two to four fill word low-to-high
// - own code 0xFF reports not configured
// - colour refresh loads selected colour point
module lin_cmd_decoder import lin_frame_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame link from the master
  lin_frame_if.slave lnk,
  // configuration
  input wire logic [7:0] ownLocation,
  input wire logic progModePin,
  // channel levels
  output logic [7:0] ch1Level,
  output logic [7:0] ch2Level,
  output logic [7:0] ch3Level,
  output logic levelLoad,
  output logic directActive,
  // colour frame settings
  output logic transEnable,
  output logic [2:0] transTime,
  output logic [3:0] colorPoint,
  output logic colorLoad,
  output logic [3:0] globalLevel,
  // nvm write request
  output logic nvmWrite,
  output logic nvmErase,
  output logic [5:0] nvmIndex,
  output logic [23:0] nvmData,
  // diagnostics
  output logic notConfigured,
  output logic cksError
);

  // captured frame
  logic capValid_reg;
  logic [7:0] capPid_reg;
  logic [31:0] capData_reg;
  logic [2:0] capLen_reg;
  logic [7:0] capCks_reg;
  // programming mode pin synchroniser
  logic progMeta_reg;
  logic progSync_reg;
  // outputs and state
  logic [7:0] ch1Level_reg;
  logic [7:0] ch2Level_reg;
  logic [7:0] ch3Level_reg;
  logic levelLoad_reg;
  logic directActive_reg;
  logic transEnable_reg;
  logic [2:0] transTime_reg;
  logic [3:0] colorPoint_reg;
  logic colorLoad_reg;
  logic [3:0] globalLevel_reg;
  logic [3:0] storedLevel_reg;
  logic nvmWrite_reg;
  logic nvmErase_reg;
  logic [5:0] nvmIndex_reg;
  logic [23:0] nvmData_reg;
  logic notConfigured_reg;
  logic cksError_reg;

  // zone membership: broadcast, own code, own zone, or the super-zone
  function automatic logic locSelects(input logic [7:0] code,
                                      input logic [7:0] own);
    logic inSuper;
    inSuper = (own[7:4] >= `LOC_SUPER_LO) && (own[7:4] <= `LOC_SUPER_HI);
    return (code == `LOC_BROADCAST) || (code == own) ||
           (code == {own[7:4], 4'h0}) ||
           (code == `LOC_SUPER && inSuper);
  endfunction

  // byte views
  wire logic [7:0] byte1 = capData_reg[7:0];
  wire logic [7:0] byte2 = capData_reg[15:8];
  wire logic [7:0] byte3 = capData_reg[23:16];
  wire logic [7:0] byte4 = capData_reg[31:24];
  wire logic [5:0] frameId = capPid_reg[5:0];

  // frame validation
  wire logic pidOk = capPid_reg == makePid(frameId);
  wire logic cksOk =
    capCks_reg == enhCks(capPid_reg, capData_reg, capLen_reg);
  wire logic frameOk = capValid_reg && pidOk && cksOk;
  wire logic selected = locSelects(byte1, ownLocation);
  wire logic isDirect = frameId == `FID_DIRECT && capLen_reg == `LEN_CMD;
  wire logic isNvm = frameId == `FID_NVM && capLen_reg == `LEN_CMD;
  wire logic isColor = frameId == `FID_COLOR && capLen_reg == `LEN_COLOR;

  // accepted commands; anything else leaves the state untouched
  wire logic takeDirect = frameOk && isDirect && selected;
  wire logic takeColor = frameOk && isColor && selected;
  wire logic [5:0] wordIdx = byte1[`NVM_INDEX_HI:0];
  wire logic indexOk = wordIdx <= `NVM_MAX_INDEX;
  // no error output exists for a dropped nvm frame on purpose
  wire logic takeNvm =
    frameOk && isNvm && progSync_reg && indexOk;

  // colour frame fields
  wire logic colorRefresh = byte2[`COL_UPDATE_BIT];
  wire logic [1:0] intMode = byte3[`INT_MODE_HI:`INT_MODE_LO];
  wire logic [3:0] intValue = byte3[`INT_VALUE_HI:0];
  wire logic [2:0] newTransTime = {byte3[`COL_TRANS_T2_BIT],
                                   byte3[`COL_TRANS_T1_BIT],
                                   byte2[`COL_TRANS_T0_BIT]};
  wire logic applyNew = intMode == `INT_MODE_APPLY;
  wire logic storeNew = applyNew || intMode == `INT_MODE_STORE;
  wire logic applyStored = intMode == `INT_MODE_STORED;

  // link inputs are same-clock logic: one capture stage only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capValid_reg <= 1'b0;
      capPid_reg <= 8'h00;
      capData_reg <= 32'h0000_0000;
      capLen_reg <= 3'h0;
      capCks_reg <= 8'h00;
    end else begin
      capValid_reg <= lnk.frmValid;
      capPid_reg <= lnk.frmPid;
      capData_reg <= lnk.frmData;
      capLen_reg <= lnk.frmLen;
      capCks_reg <= lnk.frmCks;
    end
  end

  // mode pin comes from outside, so two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progMeta_reg <= 1'b0;
      progSync_reg <= 1'b0;
    end else begin
      progMeta_reg <= progModePin;
      progSync_reg <= progMeta_reg;
    end
  end

  // channel levels and the direct/colour ownership flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch1Level_reg <= 8'h00;
      ch2Level_reg <= 8'h00;
      ch3Level_reg <= 8'h00;
      levelLoad_reg <= 1'b0;
      directActive_reg <= 1'b0;
      colorLoad_reg <= 1'b0;
      colorPoint_reg <= 4'h0;
    end else begin
      levelLoad_reg <= takeDirect;
      colorLoad_reg <= takeColor && colorRefresh;
      if (takeDirect) begin
        ch1Level_reg <= byte2;
        ch2Level_reg <= byte3;
        ch3Level_reg <= byte4;
        directActive_reg <= 1'b1;
      end else if (takeColor && colorRefresh) begin
        // refresh hands the channels back to the stored colour points
        colorPoint_reg <= byte2[`COL_POINT_HI:`COL_POINT_LO];
        directActive_reg <= 1'b0;
      end
    end
  end

  // transition settings follow every selected colour frame, the global level
  // those with int mode apply or stored, with or without refresh, so a direct frame reuses them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      transEnable_reg <= 1'b0;
      transTime_reg <= 3'h0;
      globalLevel_reg <= 4'h0;
      storedLevel_reg <= 4'h0;
    end else if (takeColor) begin
      transEnable_reg <= byte2[`COL_TRANS_EN_BIT];
      transTime_reg <= newTransTime;
      if (storeNew) begin
        storedLevel_reg <= intValue;
      end
      if (applyNew) begin
        globalLevel_reg <= intValue;
      end else if (applyStored) begin
        globalLevel_reg <= storedLevel_reg;
      end
    end
  end

  // nvm write request, one-cycle pulse with held fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvmWrite_reg <= 1'b0;
      nvmErase_reg <= 1'b0;
      nvmIndex_reg <= 6'h00;
      nvmData_reg <= 24'h00_0000;
    end else begin
      nvmWrite_reg <= takeNvm;
      if (takeNvm) begin
        // bit 6 is ignored here; the master keeps it at zero
        nvmErase_reg <= byte1[`NVM_ERASE_BIT];
        nvmIndex_reg <= wordIdx;
        nvmData_reg <= {byte4, byte3, byte2};
      end
    end
  end

  // diagnostics
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      notConfigured_reg <= 1'b0;
      cksError_reg <= 1'b0;
    end else begin
      notConfigured_reg <= ownLocation == `LOC_UNCONFIG;
      cksError_reg <= capValid_reg && !(pidOk && cksOk);
    end
  end

  assign ch1Level = ch1Level_reg;
  assign ch2Level = ch2Level_reg;
  assign ch3Level = ch3Level_reg;
  assign levelLoad = levelLoad_reg;
  assign directActive = directActive_reg;
  assign transEnable = transEnable_reg;
  assign transTime = transTime_reg;
  assign colorPoint = colorPoint_reg;
  assign colorLoad = colorLoad_reg;
  assign globalLevel = globalLevel_reg;
  assign nvmWrite = nvmWrite_reg;
  assign nvmErase = nvmErase_reg;
  assign nvmIndex = nvmIndex_reg;
  assign nvmData = nvmData_reg;
  assign notConfigured = notConfigured_reg;
  assign cksError = cksError_reg;

endmodule

// ---- core/lin_cmd_master.sv ----
// master end: apb-programmed frame builder for the led slave commands
`include "lin_frame_map.svh"

module lin_cmd_master import lin_frame_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame link to the slave
  lin_frame_if.master lnk
);

  logic [31:0] data_reg;
  logic [2:0] ctrl_reg;
  logic sent_reg;
  logic drop_reg;
  host_state_t state_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic frmValid_reg;
  logic [7:0] frmPid_reg;
  logic [31:0] frmData_reg;
  logic [2:0] frmLen_reg;
  logic [7:0] frmCks_reg;

  // bus decode; access takes effect on the edge where pready is high
  wire logic [3:0] addr = paddr[3:0];
  wire logic access = psel && penable && pready_reg;
  wire logic isData = paddr[31:4] == 28'h0 && addr == `ADDR_DATA;
  wire logic isCtrl = paddr[31:4] == 28'h0 && addr == `ADDR_CTRL;
  wire logic isGo = paddr[31:4] == 28'h0 && addr == `ADDR_GO;
  wire logic isStat = paddr[31:4] == 28'h0 && addr == `ADDR_STATUS;
  wire logic mapped = isData || isCtrl || isGo || isStat;
  wire logic wrAcc = access && pwrite;
  wire logic busy = state_reg != ST_IDLE;
  wire logic [31:0] statusWord = {29'h0, drop_reg, sent_reg, busy};
  wire logic [31:0] rdMux = isData ? data_reg :
                            isCtrl ? {29'h0, ctrl_reg} :
                            isStat ? statusWord : 32'h0000_0000;

  // a go while busy is ignored
  wire logic go = wrAcc && isGo && !busy;
  wire logic [1:0] kind = ctrl_reg[1:0];
  wire logic prodOn = ctrl_reg[`CTRL_PROD_BIT];
  wire logic kindOk = kind == `KIND_COLOR || kind == `KIND_DIRECT ||
                      (kind == `KIND_NVM && prodOn);
  wire logic [5:0] fid = kind == `KIND_COLOR ? `FID_COLOR :
                         kind == `KIND_DIRECT ? `FID_DIRECT : `FID_NVM;
  wire logic [2:0] len = kind == `KIND_COLOR ? `LEN_COLOR : `LEN_CMD;
  // nvm byte 1 bit 6 is forced low; unused bytes beyond len are zeroed
  wire logic [31:0] outData = kind == `KIND_NVM ?
    {data_reg[31:7], 1'b0, data_reg[5:0]} :
    (kind == `KIND_COLOR ? {8'h00, data_reg[23:0]} : data_reg);
  wire logic [7:0] pid = makePid(fid);
  wire logic stClr = wrAcc && isStat;

  // apb answer: one wait state so read data comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      prdata_reg <= (psel && !pwrite) ? rdMux : 32'h0000_0000;
      pslverr_reg <= psel && penable && !pready_reg && !mapped;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_reg <= 32'h0000_0000;
      ctrl_reg <= 3'h0;
    end else begin
      if (wrAcc && isData) begin
        data_reg <= pwdata;
      end
      if (wrAcc && isCtrl) begin
        ctrl_reg <= pwdata[2:0];
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sent_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      sent_reg <= (state_reg == ST_SEND) ||
                  (sent_reg && !(stClr && pwdata[`ST_SENT_BIT]));
      drop_reg <= (go && !kindOk) ||
                  (drop_reg && !(stClr && pwdata[`ST_DROP_BIT]));
    end
  end

  // software orders direct then colour frames itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      frmValid_reg <= 1'b0;
      frmPid_reg <= 8'h00;
      frmData_reg <= 32'h0000_0000;
      frmLen_reg <= 3'h0;
      frmCks_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          frmValid_reg <= 1'b0;
          if (go && kindOk) begin
            frmValid_reg <= 1'b1;
            frmPid_reg <= pid;
            frmData_reg <= outData;
            frmLen_reg <= len;
            frmCks_reg <= enhCks(pid, outData, len);
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          frmValid_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign lnk.frmValid = frmValid_reg;
  assign lnk.frmPid = frmPid_reg;
  assign lnk.frmData = frmData_reg;
  assign lnk.frmLen = frmLen_reg;
  assign lnk.frmCks = frmCks_reg;

endmodule

// ---- tb/lin_cmd_properties.sv ----
// concurrent checks on the frame link and the slave decoder outputs
`include "lin_frame_map.svh"
module lin_cmd_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame link
  input wire logic frmValid,
  input wire logic [7:0] frmPid,
  input wire logic [31:0] frmData,
  input wire logic [2:0] frmLen,
  input wire logic [7:0] frmCks,
  // slave configuration
  input wire logic [7:0] ownLocation,
  input wire logic progModePin,
  // slave outputs
  input wire logic [7:0] ch1Level,
  input wire logic [7:0] ch2Level,
  input wire logic [7:0] ch3Level,
  input wire logic levelLoad,
  input wire logic directActive,
  input wire logic transEnable,
  input wire logic [2:0] transTime,
  input wire logic colorLoad,
  input wire logic nvmWrite,
  input wire logic nvmErase,
  input wire logic [5:0] nvmIndex,
  input wire logic [23:0] nvmData,
  input wire logic cksError
);
  timeunit 1ns;
  timeprecision 1ps;

  // own sum so a shared slip in the design helper cannot hide
  function automatic logic [7:0] sumCks(input logic [7:0] p,
                                        input logic [31:0] d,
                                        input logic [2:0] n);
    logic [8:0] s;
    s = {1'b0, p};
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < n) begin
        s = s + {1'b0, d[8*i +: 8]};
        if (s[8]) begin
          s = s - 9'h0FF;
        end
      end
    end
    return ~s[7:0];
  endfunction

  wire logic [5:0] fid = frmPid[5:0];
  wire logic [7:0] loc = frmData[7:0];
  wire logic [3:0] zone = ownLocation[7:4];
  wire logic superHit = loc == `LOC_SUPER && zone >= `LOC_SUPER_LO &&
                        zone <= `LOC_SUPER_HI;
  wire logic locSel = loc == `LOC_BROADCAST || loc == ownLocation ||
                      loc == {zone, 4'h0} || superHit;
  wire logic parOk = frmPid[6] == ^{fid[0], fid[1], fid[2], fid[4]} &&
                     frmPid[7] == ~^{fid[1], fid[3], fid[4], fid[5]};
  wire logic cksOk = parOk && frmCks == sumCks(frmPid, frmData, frmLen);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_direct;
    frmValid && cksOk && fid == `FID_DIRECT && locSel;
  endsequence
  sequence s_nvm_on;
    progModePin [*3] ##0 frmValid && cksOk && fid == `FID_NVM;
  endsequence
  sequence s_nvm_off;
    !progModePin [*3] ##0 frmValid && fid == `FID_NVM;
  endsequence

  property p_cks_wire;
    frmValid |-> cksOk;
  endproperty
  property p_len;
    frmValid |-> frmLen == (fid == `FID_COLOR ? `LEN_COLOR : `LEN_CMD);
  endproperty
  property p_direct_load;
    s_direct |-> ##2 levelLoad && directActive &&
      {ch1Level, ch2Level, ch3Level} == {$past(frmData[15:8], 2),
      $past(frmData[23:16], 2), $past(frmData[31:24], 2)};
  endproperty
  property p_unsel;
    frmValid && fid == `FID_DIRECT && !locSel |-> ##2 !levelLoad;
  endproperty
  property p_trans;
    levelLoad |-> $stable(transEnable) && $stable(transTime);
  endproperty
  property p_hold;
    $changed({ch1Level, ch2Level, ch3Level}) |-> levelLoad;
  endproperty
  property p_refresh;
    colorLoad |-> !directActive;
  endproperty
  property p_nvm_write;
    s_nvm_on ##0 frmData[5:0] <= `NVM_MAX_INDEX |-> ##2 nvmWrite &&
      nvmErase == $past(frmData[7], 2) && nvmIndex == $past(frmData[5:0], 2)
      && nvmData == $past(frmData[31:8], 2);
  endproperty
  property p_nvm_drop;
    s_nvm_off |-> ##2 !nvmWrite && !cksError;
  endproperty
  property p_nvm_bit6;
    frmValid && fid == `FID_NVM |-> !frmData[`NVM_ZERO_BIT];
  endproperty

  a_cks_wire: assert property (p_cks_wire)
    else $error("frame sent with a bad checksum or parity");
  a_len: assert property (p_len)
    else $error("frame length does not fit its id");
  a_direct_load: assert property (p_direct_load)
    else $error("direct frame levels not loaded two cycles later");
  a_unsel: assert property (p_unsel)
    else $error("unselected direct frame loaded levels");
  a_trans: assert property (p_trans)
    else $error("direct frame altered transition settings");
  a_hold: assert property (p_hold)
    else $error("channel levels changed without a load");
  a_refresh: assert property (p_refresh)
    else $error("colour refresh left direct levels active");
  a_nvm_write: assert property (p_nvm_write)
    else $error("nvm write request wrong");
  a_nvm_drop: assert property (p_nvm_drop)
    else $error("nvm frame acted on outside programming mode");
  a_nvm_bit6: assert property (p_nvm_bit6)
    else $error("nvm frame byte one bit six not zero");
endmodule

// ---- tb/lin_direct_intensity_nvm_write_decoder_tb.sv ----
// self-checking bench: apb master end driving the led slave decoder
`include "lin_frame_map.svh"
module lin_direct_intensity_nvm_write_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, progModePin;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] ownLocation, ch1Level, ch2Level, ch3Level;
  logic levelLoad, directActive, transEnable, colorLoad, nvmWrite;
  logic nvmErase, notConfigured, cksError, levelLoad2, cksError2;
  logic [2:0] transTime;
  logic [3:0] globalLevel, colorPoint;
  logic [5:0] nvmIndex;
  logic [23:0] nvmData;
  int failures, total_checks, cycles;
  logic [23:0] qLvl[$];
  logic [30:0] qNvm[$];
  wire logic [23:0] lvlNow = {ch1Level, ch2Level, ch3Level};
  wire logic [30:0] nvmNow = {nvmErase, nvmIndex, nvmData};
  lin_frame_if lnk();
  lin_frame_if lnk2();

  lin_cmd_master lin_cmd_master_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  lin_cmd_decoder lin_cmd_decoder_inst (.clk(clk), .rst(rst), .lnk(lnk),
    .ownLocation(ownLocation), .progModePin(progModePin),
    .ch1Level(ch1Level), .ch2Level(ch2Level), .ch3Level(ch3Level),
    .levelLoad(levelLoad), .directActive(directActive),
    .transEnable(transEnable), .transTime(transTime), .colorPoint(colorPoint),
    .colorLoad(colorLoad), .globalLevel(globalLevel), .nvmWrite(nvmWrite),
    .nvmErase(nvmErase), .nvmIndex(nvmIndex), .nvmData(nvmData),
    .notConfigured(notConfigured), .cksError(cksError));
  // second slave fed by the bench with one deliberately broken frame
  lin_cmd_decoder lin_cmd_decoder_inst2 (.clk(clk), .rst(rst), .lnk(lnk2),
    .ownLocation(ownLocation), .progModePin(progModePin), .ch1Level(),
    .ch2Level(), .ch3Level(), .levelLoad(levelLoad2), .directActive(),
    .transEnable(), .transTime(), .colorPoint(), .colorLoad(),
    .globalLevel(), .nvmWrite(), .nvmErase(), .nvmIndex(), .nvmData(),
    .notConfigured(), .cksError(cksError2));
  lin_cmd_properties props (.clk(clk), .rst(rst),
    .frmValid(lnk.frmValid), .frmPid(lnk.frmPid), .frmData(lnk.frmData),
    .frmLen(lnk.frmLen), .frmCks(lnk.frmCks), .ownLocation(ownLocation),
    .progModePin(progModePin), .ch1Level(ch1Level), .ch2Level(ch2Level),
    .ch3Level(ch3Level), .levelLoad(levelLoad), .directActive(directActive),
    .transEnable(transEnable), .transTime(transTime), .colorLoad(colorLoad),
    .nvmWrite(nvmWrite), .nvmErase(nvmErase), .nvmIndex(nvmIndex),
    .nvmData(nvmData), .cksError(cksError));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic note(input string what, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: %s exp %h got %h", $time, what, e, g);
    end
  endtask
  task automatic chkLevels(input logic [23:0] e, g);
    note("levels", 32'(e), 32'(g));
  endtask
  task automatic chkNvm(input logic [30:0] e, g);
    note("nvm request", 32'(e), 32'(g));
  endtask
  task automatic chkWord(input logic [31:0] e, g);
    note("value", e, g);
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; the wait is open-ended, the cycle ceiling cuts hangs
  task automatic apb(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // load data and kind, fire, then let the frame reach the outputs
  task automatic send(input logic [1:0] kind, input logic prod,
                      input logic [31:0] d);
    wr(32'(`ADDR_DATA), d);
    wr(32'(`ADDR_CTRL), {29'h0, prod, kind});
    wr(32'(`ADDR_GO), 32'h0);
    repeat (6) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (levelLoad === 1'b1) begin
      if (qLvl.size() == 0) note("stray load", 0, 1);
      else chkLevels(qLvl.pop_front(), lvlNow);
    end
    if (nvmWrite === 1'b1) begin
      if (qNvm.size() == 0) note("stray nvm", 0, 1);
      else chkNvm(qNvm.pop_front(), nvmNow);
    end
    if (cksError === 1'b1 || levelLoad2 === 1'b1)
      note("stray", 0, 1);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r, v;
    logic e;
    int seen;
    logic [7:0] locs[6];
    logic [6:0] cases[4];
    locs = '{8'h53, 8'h50, 8'h00, 8'h40, 8'h61, 8'h51};
    cases = '{7'h00, 7'h50, 7'h4A, 7'h11};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ownLocation = 8'h53;
    progModePin = 1'b0;
    lnk2.frmValid = 1'b0;
    lnk2.frmPid = 8'h00;
    lnk2.frmData = 32'h0;
    lnk2.frmLen = 3'h0;
    lnk2.frmCks = 8'h00;
    void'($urandom(8));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b1, 32'h10, 32'hFFFFFFFF, r, e);
    chkWord(32'h1, 32'(e));
    // own, zone, broadcast, super-zone hit; then two other slaves
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      if (i < 4) qLvl.push_back({v[7:0], v[15:8], v[23:16]});
      send(`KIND_DIRECT, 1'b0, {v[23:0], locs[i]});
    end
    chkWord(32'h1, 32'(directActive));
    send(`KIND_COLOR, 1'b0, 32'h000F4453);
    chkWord(32'h0, 32'(directActive));
    chkWord(32'h1, 32'(colorPoint));
    send(`KIND_COLOR, 1'b0, 32'h002F8253);
    v = $urandom;
    qLvl.push_back({v[7:0], v[15:8], v[23:16]});
    send(`KIND_DIRECT, 1'b0, {v[23:0], 8'h53});
    chkWord(32'h1B, 32'({transEnable, transTime, directActive}));
    send(`KIND_COLOR, 1'b0, 32'h002A8253);
    chkWord(32'h1A, 32'({directActive, globalLevel}));
    // store only, then apply the stored level
    send(`KIND_COLOR, 1'b0, 32'h00458253);
    chkWord(32'hA, 32'(globalLevel));
    send(`KIND_COLOR, 1'b0, 32'h00808253);
    chkWord(32'h5, 32'(globalLevel));
    send(`KIND_NVM, 1'b1, 32'h00ABCD05);
    progModePin <= 1'b1;
    repeat (3) @(posedge clk);
    // bit six set on purpose: the master end must clear it
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      if (cases[i][5:0] <= `NVM_MAX_INDEX)
        qNvm.push_back({cases[i], v[23:0]});
      r = {v[23:0], cases[i][6], 1'b1, cases[i][5:0]};
      send(`KIND_NVM, 1'b1, r);
    end
    progModePin <= 1'b0;
    // kind 3, then nvm without production enable: both only flag a drop
    for (int i = 0; i < 2; i++) begin
      wr(32'(`ADDR_STATUS), 32'h7);
      send(i ? `KIND_NVM : 2'h3, 1'b0, 32'h0);
      apb(1'b0, 32'(`ADDR_STATUS), 32'h0, r, e);
      chkWord(32'h4, r);
    end
    lnk2.frmValid <= 1'b1;
    lnk2.frmPid <= 8'h11;
    lnk2.frmData <= 32'h30201000;
    lnk2.frmLen <= 3'h4;
    lnk2.frmCks <= 8'h8F;
    @(posedge clk);
    lnk2.frmValid <= 1'b0;
    lnk2.frmData <= 32'hCFDFEFFF;
    seen = 0;
    repeat (4) begin
      @(posedge clk);
      if (cksError2 === 1'b1) seen++;
    end
    chkWord(32'h1, 32'(seen));
    ownLocation <= 8'hFF;
    repeat (3) @(posedge clk);
    chkWord(32'h1, 32'(notConfigured));
    chkWord(32'h0, 32'(qLvl.size() + qNvm.size()));
    tally_and_finish();
  end
endmodule
